// >>> cmcwc_core.sv
// cpu clock mode selection, clock division and wait mode control
// assumes oscillators are sampled in MCLK and run well below MCLK / 4
`timescale 1ns/1ps
module cmcwc_core #(
  parameter int PORT_WIDTH = 8
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // raw oscillator inputs
  input wire logic MAIN_CRYSTAL_CLOCK,
  input wire logic SUB_CRYSTAL_CLOCK,
  input wire logic FAST_OSC_CLOCK,
  input wire logic SLOW_OSC_CLOCK,
  // control bits, same clock domain
  input wire cmcwc_pkg::cmcwc_ctrl_type CTRL,
  // cpu wait handshake
  input wire logic WAIT_EXEC,
  input wire logic WAKE_REQ,
  // port hold
  input wire logic [PORT_WIDTH-1:0] PORT_DRIVE,
  output logic [PORT_WIDTH-1:0] PORT_OUT,
  // clocks and status
  output cmcwc_pkg::cmcwc_clocks_type CLOCKS,
  output cmcwc_pkg::cmcwc_mode_type MODE,
  output logic IN_WAIT
);
  import cmcwc_pkg::*;

  initial begin
    if (PORT_WIDTH < 1) begin
      $error("PORT_WIDTH must be at least 1");
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    cmcwc_mode_type active_mode;
    logic [CMCWC_CNT_W-1:0] active_half;
    logic [CMCWC_CNT_W-1:0] edge_cnt;
    logic cpu_clk;
    logic cpu_run;
    logic [CMCWC_PERIPH_W-1:0] periph_cnt;
    logic in_wait;
    logic [PORT_WIDTH-1:0] port_hold;
    cmcwc_clocks_type clocks;
  } cmcwc_state_type;

  cmcwc_state_type st;
  cmcwc_state_type next_st;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [CMCWC_CNT_W-1:0] half_of(input cmcwc_ctrl_type c);
    logic [CMCWC_CNT_W-1:0] h;
    h = CMCWC_HALF_DIV1;
    if (c.div_by_eight) begin
      h = CMCWC_HALF_DIV8;
    end else begin
      case ({c.cpu_div_field_hi, c.cpu_div_field_lo})
        CMCWC_FIELD_DIV1: h = CMCWC_HALF_DIV1;
        CMCWC_FIELD_DIV2: h = CMCWC_HALF_DIV2;
        CMCWC_FIELD_DIV4: h = CMCWC_HALF_DIV4;
        CMCWC_FIELD_DIV16: h = CMCWC_HALF_DIV16;
        default: h = CMCWC_HALF_DIV1;
      endcase
    end
    if (c.sub_clock_select) begin
      h = CMCWC_HALF_DIV1;
    end
    return h;
  endfunction

  function automatic cmcwc_mode_type mode_of(input cmcwc_ctrl_type c);
    cmcwc_mode_type m;
    m = CMCWC_MODE_SLOW_INT;
    if (c.sub_clock_select) begin
      m = CMCWC_MODE_SUB_SLOW;
    end else if (!c.system_clock_select) begin
      m = CMCWC_MODE_MAIN_FAST;
    end else if (c.fast_osc_enable && c.internal_osc_source) begin
      m = CMCWC_MODE_FAST_INT;
    end else begin
      m = CMCWC_MODE_SLOW_INT;
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // oscillator sampling
  // ----------------------------------------------------------------
  logic main_lvl, main_edge, main_rise;
  logic sub_lvl, sub_edge, sub_rise;
  logic fast_lvl, fast_edge, fast_rise;
  logic slow_lvl, slow_edge, slow_rise;

  cmcwc_sync u_main (.clk(MCLK), .rst(RST), .raw(MAIN_CRYSTAL_CLOCK),
    .level(main_lvl), .any_edge(main_edge), .rise(main_rise));
  cmcwc_sync u_sub (.clk(MCLK), .rst(RST), .raw(SUB_CRYSTAL_CLOCK),
    .level(sub_lvl), .any_edge(sub_edge), .rise(sub_rise));
  cmcwc_sync u_fast (.clk(MCLK), .rst(RST), .raw(FAST_OSC_CLOCK),
    .level(fast_lvl), .any_edge(fast_edge), .rise(fast_rise));
  cmcwc_sync u_slow (.clk(MCLK), .rst(RST), .raw(SLOW_OSC_CLOCK),
    .level(slow_lvl), .any_edge(slow_edge), .rise(slow_rise));

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic main_on;
    logic sub_on;
    logic fast_on;
    logic int_fast;
    logic int_lvl;
    logic int_rise;
    logic sys_lvl;
    logic sys_rise;
    logic src_edge;
    logic gate_periph;
    src_edge = 1'b0;
    gate_periph = 1'b0;
    next_st = st;
    // crystal only usable with the pins in oscillator function and not stopped
    main_on = CTRL.port_function_select && !CTRL.main_crystal_stop;
    sub_on = CTRL.sub_osc_enable;
    fast_on = CTRL.fast_osc_enable;
    int_fast = CTRL.fast_osc_enable && CTRL.internal_osc_source;
    int_lvl = int_fast ? fast_lvl : slow_lvl;
    int_rise = int_fast ? fast_rise : slow_rise;
    sys_lvl = CTRL.system_clock_select ? int_lvl : (main_lvl && main_on);
    sys_rise = CTRL.system_clock_select ? int_rise : (main_rise && main_on);

    case (st.active_mode)
      CMCWC_MODE_MAIN_FAST: src_edge = main_edge && main_on;
      CMCWC_MODE_SUB_SLOW: src_edge = sub_edge && sub_on;
      CMCWC_MODE_FAST_INT: src_edge = fast_edge && fast_on;
      CMCWC_MODE_SLOW_INT: src_edge = slow_edge;
      default: src_edge = 1'b0;
    endcase

    // wait entry wins over a simultaneous wake
    next_st.in_wait = WAIT_EXEC || (st.in_wait && !WAKE_REQ);
    if (!st.in_wait && !WAIT_EXEC) begin
      next_st.port_hold = PORT_DRIVE;
    end

    // cpu clock: selection changes only while the clock is low, after a full low phase;
    // run state changes then and also as the clock falls, so no short pulse appears
    if (src_edge) begin
      if (st.edge_cnt == st.active_half - 5'h01) begin
        next_st.edge_cnt = '0;
        if (st.cpu_clk) begin
          next_st.cpu_clk = 1'b0;
        end else if (st.cpu_run && (!st.in_wait || CTRL.osc_stop_irq_enable)) begin
          // a wait that lands mid low phase must not let one more pulse out
          next_st.cpu_clk = 1'b1;
        end
        if (!st.cpu_clk || !st.cpu_run) begin
          next_st.active_mode = mode_of(CTRL);
          next_st.active_half = half_of(CTRL);
          next_st.cpu_run = !st.in_wait || CTRL.osc_stop_irq_enable;
        end
        if (st.cpu_clk) begin
          next_st.cpu_run = !st.in_wait || CTRL.osc_stop_irq_enable;
        end
      end else begin
        next_st.edge_cnt = st.edge_cnt + 5'h01;
      end
    end

    // peripheral clocks from system clock rising edges
    gate_periph = st.in_wait && CTRL.periph_clock_stop_in_wait;
    if (!gate_periph && sys_rise) begin
      next_st.periph_cnt = st.periph_cnt + 5'h01;
    end
    next_st.clocks.periph_clock[0] = sys_lvl && !gate_periph;
    next_st.clocks.periph_clock[1] = st.periph_cnt[CMCWC_F2_BIT] && !gate_periph;
    next_st.clocks.periph_clock[2] = st.periph_cnt[CMCWC_F4_BIT] && !gate_periph;
    next_st.clocks.periph_clock[3] = st.periph_cnt[CMCWC_F8_BIT] && !gate_periph;
    next_st.clocks.periph_clock[4] = st.periph_cnt[CMCWC_F32_BIT] && !gate_periph;

    // oscillator clocks keep running in wait
    next_st.clocks.cpu_clock = st.cpu_clk;
    next_st.clocks.internal_osc_periph_clock =
      int_lvl && (!CTRL.slow_osc_disable || CTRL.fast_osc_enable);
    next_st.clocks.fast_osc_timer_clock = fast_lvl && CTRL.fast_osc_enable;
    next_st.clocks.slow_osc_watchdog_clock = slow_lvl && !CTRL.slow_osc_disable;
    // protected watchdog counts the slow clock and so survives wait
    next_st.clocks.watchdog_clock = CTRL.count_source_protect ?
      (slow_lvl && !CTRL.slow_osc_disable) : st.cpu_clk;
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      st <= '0;
      st.active_mode <= CMCWC_MODE_SLOW_INT;
      st.active_half <= CMCWC_HALF_RESET;
      st.cpu_run <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign CLOCKS = st.clocks;
  assign MODE = st.active_mode;
  assign IN_WAIT = st.in_wait;
  assign PORT_OUT = st.port_hold;
endmodule

// >>> cmcwc_core_assertions.sv
// concurrent checks on the ports of the clock mode and wait core
// assumes it is bound to cmcwc_core and runs in the single MCLK domain
`timescale 1ns/1ps
module cmcwc_core_assertions
  import cmcwc_pkg::*;
#(
  parameter int PORT_WIDTH = 8
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // control and wait inputs
  input wire cmcwc_pkg::cmcwc_ctrl_type CTRL,
  input wire logic WAIT_EXEC,
  input wire logic WAKE_REQ,
  // outputs
  input wire logic [PORT_WIDTH-1:0] PORT_OUT,
  input wire cmcwc_pkg::cmcwc_clocks_type CLOCKS,
  input wire cmcwc_pkg::cmcwc_mode_type MODE,
  input wire logic IN_WAIT
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  // four cycles cover two sync flops, the output flop and control sampling
  sequence fast_off_s; !CTRL.fast_osc_enable [*4]; endsequence
  sequence slow_off_s; CTRL.slow_osc_disable [*4]; endsequence
  sequence osc_idle_s; (CTRL.slow_osc_disable && !CTRL.fast_osc_enable) [*4]; endsequence
  // one cycle more than the wait flag: the clock output trails the state by a flop
  sequence parked_s;
    (IN_WAIT && !CTRL.osc_stop_irq_enable)
    ##1 (IN_WAIT && !CTRL.osc_stop_irq_enable && !CLOCKS.cpu_clock)
    ##1 (IN_WAIT && !CTRL.osc_stop_irq_enable);
  endsequence
  reset_state_a: assert property ($fell(RST) |-> CLOCKS == '0 && !IN_WAIT
    && PORT_OUT == '0 && MODE == CMCWC_MODE_SLOW_INT) else $error("bad state after reset");
  wait_entry_a: assert property (WAIT_EXEC |=> IN_WAIT)
    else $error("wait strobe did not enter wait");
  wait_exit_a: assert property (IN_WAIT && WAKE_REQ && !WAIT_EXEC |=> !IN_WAIT)
    else $error("wake did not leave wait");
  wait_stay_a: assert property (IN_WAIT && !WAKE_REQ |=> IN_WAIT)
    else $error("wait left without wake");
  port_hold_a: assert property (IN_WAIT && $past(IN_WAIT) |-> $stable(PORT_OUT))
    else $error("port moved during wait");
  cpu_parked_a: assert property (parked_s |-> !CLOCKS.cpu_clock)
    else $error("cpu clock restarted in wait");
  periph_stop_a: assert property ((IN_WAIT && CTRL.periph_clock_stop_in_wait) [*2]
    |-> CLOCKS.periph_clock == 5'h00) else $error("periph clock ran in wait");
  fast_gate_a: assert property (fast_off_s |-> !CLOCKS.fast_osc_timer_clock)
    else $error("fast timer clock not gated");
  slow_gate_a: assert property (slow_off_s |-> !CLOCKS.slow_osc_watchdog_clock)
    else $error("watchdog slow clock not gated");
  event_gate_a: assert property (osc_idle_s |-> !CLOCKS.internal_osc_periph_clock)
    else $error("event timer clock not gated");
endmodule

bind cmcwc_core cmcwc_core_assertions #(.PORT_WIDTH(PORT_WIDTH)) chk (.MCLK(MCLK), .RST(RST),
  .CTRL(CTRL), .WAIT_EXEC(WAIT_EXEC), .WAKE_REQ(WAKE_REQ), .PORT_OUT(PORT_OUT),
  .CLOCKS(CLOCKS), .MODE(MODE), .IN_WAIT(IN_WAIT));

// >>> cmcwc_core_tb.sv
// self-checking bench for the clock mode and wait core
// assumes the package, core and bound checker are compiled before it
`timescale 1ns/1ps
module cmcwc_core_tb;
  import cmcwc_pkg::*;
  localparam int FDIV[5] = '{1, 2, 4, 16, 8};
  localparam int PDIV[5] = '{1, 2, 4, 8, 32};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic osc_main = 1'b0;
  logic osc_sub = 1'b0;
  logic osc_fast = 1'b0;
  logic osc_slow = 1'b0;
  logic wait_exec = 1'b0;
  logic wake_req = 1'b0;
  logic [7:0] port_drive = 8'h00;
  logic [7:0] port_out;
  logic in_wait;
  logic [9:0] pv;
  cmcwc_ctrl_type ctrl;
  cmcwc_ctrl_type c;
  cmcwc_clocks_type clocks;
  cmcwc_mode_type mode;
  int cyc;
  int fail_count;
  int comparisons;
  int r;
  int last[10];
  int per[10];
  int rises[10];

  initial forever #2 mclk = ~mclk;
  // edges land between MCLK rising edges, so measured periods are exact
  always #16 osc_main = ~osc_main;
  always #24 osc_sub = ~osc_sub;
  always #20 osc_fast = ~osc_fast;
  always #40 osc_slow = ~osc_slow;

  cmcwc_core uut (.MCLK(mclk), .RST(rst), .MAIN_CRYSTAL_CLOCK(osc_main),
    .SUB_CRYSTAL_CLOCK(osc_sub), .FAST_OSC_CLOCK(osc_fast), .SLOW_OSC_CLOCK(osc_slow),
    .CTRL(ctrl), .WAIT_EXEC(wait_exec), .WAKE_REQ(wake_req), .PORT_DRIVE(port_drive),
    .PORT_OUT(port_out), .CLOCKS(clocks), .MODE(mode), .IN_WAIT(in_wait));

  // sampled on the falling edge, where the registered clock outputs have settled
  always @(negedge mclk) begin
    cyc <= cyc + 1;
    pv <= clocks;
    for (int i = 0; i < 10; i++) begin
      if (clocks[i] && !pv[i]) begin
        per[i] <= cyc - last[i];
        last[i] <= cyc;
        rises[i] <= rises[i] + 1;
      end
    end
    if (cyc == 30000) begin
      fail_count++;
      end_of_test;
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task setc;
    @(posedge mclk);
    ctrl <= c;
  endtask

  // period of clock bit i in MCLK cycles, once the old divisor has drained
  task meas(input int i, input int e);
    repeat (3 * e + 200) @(posedge mclk);
    #1 check(per[i], e);
  endtask

  // whether clock bit i toggles within a window
  task run(input int i, input logic e);
    repeat (10) @(posedge mclk);
    r = rises[i];
    repeat (200) @(posedge mclk);
    check(rises[i] - r > 0, e);
  endtask

  initial begin
    c = '0;
    c.system_clock_select = 1'b1;
    c.div_by_eight = 1'b1;
    ctrl = c;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1 check(mode, CMCWC_MODE_SLOW_INT);
    check(port_out, 8'h00);
    meas(9, 160);
    for (int f = 0; f < 5; f++) begin
      c.div_by_eight = (f == 4);
      {c.cpu_div_field_hi, c.cpu_div_field_lo} = f[1:0];
      setc;
      meas(9, FDIV[f] * 20);
      check(mode, CMCWC_MODE_SLOW_INT);
    end
    for (int p = 0; p < 5; p++) meas(p, PDIV[p] * 20);
    c.slow_osc_disable = 1'b1;
    setc;
    run(7, 1'b0);
    run(5, 1'b0);
    run(6, 1'b0);
    c.fast_osc_enable = 1'b1;
    setc;
    run(6, 1'b1);
    run(7, 1'b1);
    run(5, 1'b0);
    c.slow_osc_disable = 1'b0;
    setc;
    run(5, 1'b1);
    c.internal_osc_source = 1'b1;
    c.div_by_eight = 1'b0;
    c.cpu_div_field_lo = 1'b1;
    setc;
    meas(9, 20);
    check(mode, CMCWC_MODE_FAST_INT);
    // divide-by-eight goes on before every internal to main move
    c.div_by_eight = 1'b1;
    setc;
    meas(9, 80);
    c.system_clock_select = 1'b0;
    c.port_function_select = 1'b1;
    setc;
    meas(9, 64);
    check(mode, CMCWC_MODE_MAIN_FAST);
    c.div_by_eight = 1'b0;
    setc;
    meas(9, 16);
    c.sub_osc_enable = 1'b1;
    c.sub_clock_select = 1'b1;
    setc;
    meas(9, 12);
    check(mode, CMCWC_MODE_SUB_SLOW);
    c.sub_clock_select = 1'b0;
    c.div_by_eight = 1'b1;
    setc;
    c.system_clock_select = 1'b1;
    c.internal_osc_source = 1'b0;
    setc;
    c.div_by_eight = 1'b0;
    c.cpu_div_field_lo = 1'b0;
    setc;
    meas(9, 20);
    // slow mode lets software stop the main crystal and the fast oscillator
    c.main_crystal_stop = 1'b1;
    c.fast_osc_enable = 1'b0;
    setc;
    meas(9, 20);
    run(6, 1'b0);
    for (int w = 0; w < 2; w++) begin
      c.osc_stop_irq_enable = w[0];
      c.count_source_protect = w[0];
      c.periph_clock_stop_in_wait = !w[0];
      if (w == 1) begin
        // a live stop irq in wait needs the crystal as system clock
        c.main_crystal_stop = 1'b0;
        c.div_by_eight = 1'b1;
        setc;
        c.system_clock_select = 1'b0;
      end
      setc;
      port_drive <= 8'hA5;
      repeat (4) @(posedge mclk);
      wait_exec <= 1'b1;
      @(posedge mclk);
      wait_exec <= 1'b0;
      port_drive <= 8'h3C;
      #1 check(in_wait, 1'b1);
      repeat (40) @(posedge mclk);
      run(9, w[0]);
      run(8, w[0]);
      run(0, w[0]);
      run(7, 1'b1);
      check(port_out, 8'hA5);
      wake_req <= 1'b1;
      @(posedge mclk);
      wake_req <= 1'b0;
      #1 check(in_wait, 1'b0);
      repeat (3) @(posedge mclk);
      #1 check(port_out, 8'h3C);
    end
    end_of_test;
  end
endmodule

// >>> cmcwc_pkg.sv
// package for the cpu clock mode and wait control block
// assumes one 250 MHz MCLK domain; oscillator inputs arrive asynchronously
package cmcwc_pkg;

  // ----------------------------------------------------------------
  // counts and reset values
  // ----------------------------------------------------------------
  localparam int CMCWC_CNT_W = 5;
  localparam int CMCWC_PERIPH_W = 5;
  // source edges (rise and fall) per cpu clock half period, one per divisor
  localparam logic [4:0] CMCWC_HALF_DIV1 = 5'h01;
  localparam logic [4:0] CMCWC_HALF_DIV2 = 5'h02;
  localparam logic [4:0] CMCWC_HALF_DIV4 = 5'h04;
  localparam logic [4:0] CMCWC_HALF_DIV8 = 5'h08;
  localparam logic [4:0] CMCWC_HALF_DIV16 = 5'h10;
  localparam logic [4:0] CMCWC_HALF_RESET = CMCWC_HALF_DIV8;
  localparam logic [1:0] CMCWC_FIELD_DIV1 = 2'h0;
  localparam logic [1:0] CMCWC_FIELD_DIV2 = 2'h1;
  localparam logic [1:0] CMCWC_FIELD_DIV4 = 2'h2;
  localparam logic [1:0] CMCWC_FIELD_DIV16 = 2'h3;
  // periph counter bit positions for f2, f4, f8 and f32
  localparam int CMCWC_F2_BIT = 0;
  localparam int CMCWC_F4_BIT = 1;
  localparam int CMCWC_F8_BIT = 2;
  localparam int CMCWC_F32_BIT = 4;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CMCWC_MODE_MAIN_FAST,
    CMCWC_MODE_SUB_SLOW,
    CMCWC_MODE_FAST_INT,
    CMCWC_MODE_SLOW_INT
  } cmcwc_mode_type;

  typedef struct packed {
    logic system_clock_select;
    logic osc_stop_irq_enable;
    logic cpu_div_field_hi;
    logic cpu_div_field_lo;
    logic slow_osc_disable;
    logic port_function_select;
    logic sub_clock_select;
    logic div_by_eight;
    logic main_crystal_stop;
    logic sub_osc_enable;
    logic periph_clock_stop_in_wait;
    logic fast_osc_enable;
    logic internal_osc_source;
    logic count_source_protect;
  } cmcwc_ctrl_type;

  // f1, f2, f4, f8, f32 from bit 0 upward
  typedef struct packed {
    logic cpu_clock;
    logic watchdog_clock;
    logic internal_osc_periph_clock;
    logic fast_osc_timer_clock;
    logic slow_osc_watchdog_clock;
    logic [4:0] periph_clock;
  } cmcwc_clocks_type;

  typedef struct packed {
    logic stage1;
    logic stage2;
    logic stage3;
  } cmcwc_sync_state_type;

endpackage

// >>> cmcwc_sync.sv
// two-flop synchroniser with a third flop for edge detection
// assumes the raw input is asynchronous to clk
`timescale 1ns/1ps
module cmcwc_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // raw oscillator level
  input wire logic raw,
  // synchronised level and edge pulses
  output logic level,
  output logic any_edge,
  output logic rise
);
  import cmcwc_pkg::*;

  cmcwc_sync_state_type st;
  cmcwc_sync_state_type next_st;

  always_comb begin
    next_st.stage1 = raw;
    next_st.stage2 = st.stage1;
    next_st.stage3 = st.stage2;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // stage1 feeds stage2 only
  assign level = st.stage2;
  assign any_edge = st.stage2 ^ st.stage3;
  assign rise = st.stage2 & ~st.stage3;
endmodule
